// ===== shared/corr_regs_pkg.sv
// Register map, field layout and reset values of the ambient phase correction bank.
// Assumes a single clock domain shared by the two-wire port and the depth core.
package corr_regs_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_MIX_A = 8'hb1;
  localparam logic [7:0] REG_FOURTH_HIGH_CH2 = 8'hb2;
  localparam logic [7:0] REG_SLOPES = 8'hb4;
  localparam logic [7:0] REG_SCALE = 8'hb5;
  localparam logic [7:0] REG_KNEES = 8'hb8;
  localparam logic [7:0] REG_KNEE_THIRD = 8'hb9;

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int DATA_W = 24;
  localparam int BYTE_W = 8;
  localparam int COEFF_W = 16;
  localparam int SLOPE_W = 8;
  localparam int SCALE_W = 3;
  localparam int KNEE_W = 10;
  localparam int AMB_W = 10;
  localparam int COEFF_LSB = 0;
  localparam int FOURTH_LOW_LSB = 16;
  localparam int SLOPE1_LSB = 0;
  localparam int SLOPE2_LSB = 8;
  localparam int SLOPE3_LSB = 16;
  localparam int SCALE_LSB = 0;
  localparam int KNEE1_LSB = 0;
  localparam int KNEE2_LSB = 10;
  localparam int KNEE3_LSB = 0;
  localparam int DEALIAS_BIT = 20;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [KNEE_W-1:0] KNEE_RESET = 10'h1ff;
  localparam logic [DATA_W-1:0] KNEES_REG_RESET = 24'h07_fdff;

  // ----------------------------------------------------------------
  // Two-wire port framing
  // ----------------------------------------------------------------
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] FIRST_BIT_SENT = 4'h1;
  localparam logic [1:0] LAST_BYTE = 2'h2;
  localparam logic [6:0] DEFAULT_DEV_ADDR = 7'h2a;

  // ----------------------------------------------------------------
  // Illumination channels and segments
  // ----------------------------------------------------------------
  localparam logic [1:0] CHAN_0 = 2'h0;
  localparam logic [1:0] CHAN_2 = 2'h2;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_REG, ST_REG_ACK, ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK
  } port_state_t;

  typedef enum logic [1:0] {SEG_FLAT, SEG_ONE, SEG_TWO, SEG_THREE} segment_t;

endpackage

// ===== shared/corr_cfg_if.sv
// Configuration carried from the register bank to the correction unit.
// Assumes both ends run on the same clock; the fields are plain register copies.
`timescale 1ns/1ps
interface corr_cfg_if;
  import corr_regs_pkg::*;
  logic [COEFF_W-1:0] third_order_high_ch0;
  logic [COEFF_W-1:0] fourth_order_high_ch2;
  logic [BYTE_W-1:0] fourth_order_low_ch2;
  logic [SLOPE_W-1:0] ambient_slope_one;
  logic [SLOPE_W-1:0] ambient_slope_two;
  logic [SLOPE_W-1:0] ambient_slope_three;
  logic [SCALE_W-1:0] ambient_slope_scale;
  logic [KNEE_W-1:0] ambient_knee_first;
  logic [KNEE_W-1:0] ambient_knee_second;
  logic [KNEE_W-1:0] ambient_knee_third;
  logic dealiased_output_select;

  modport regs (
    output third_order_high_ch0, fourth_order_high_ch2, fourth_order_low_ch2,
    output ambient_slope_one, ambient_slope_two, ambient_slope_three, ambient_slope_scale,
    output ambient_knee_first, ambient_knee_second, ambient_knee_third, dealiased_output_select
  );
  modport corr (
    input third_order_high_ch0, fourth_order_high_ch2, fourth_order_low_ch2,
    input ambient_slope_one, ambient_slope_two, ambient_slope_three, ambient_slope_scale,
    input ambient_knee_first, ambient_knee_second, ambient_knee_third, dealiased_output_select
  );
endinterface

// ===== core/ambient_corr_unit.sv
// Per-measurement coefficient pick and ambient piecewise-linear phase correction.
// Assumes measurement inputs come from logic on the same clock.
`timescale 1ns/1ps
module ambient_corr_unit #(
  parameter int PHASE_W = 16
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic ce,
  corr_cfg_if.corr cfg,
  input wire logic measure_start,
  input wire logic [1:0] channel,
  input wire logic high_current,
  input wire logic [corr_regs_pkg::AMB_W-1:0] ambient,
  input wire logic [PHASE_W-1:0] phase_in,
  input wire logic [PHASE_W-1:0] dealiased_phase,
  output logic [PHASE_W-1:0] phase_out,
  output logic [corr_regs_pkg::COEFF_W-1:0] third_coeff,
  output logic [corr_regs_pkg::COEFF_W-1:0] fourth_coeff,
  output logic [1:0] segment,
  output logic result_valid
);
  import corr_regs_pkg::*;

  if (PHASE_W < COEFF_W) begin : g_width_check
    $error("PHASE_W too narrow for the correction term");
  end

  localparam int PROD_W = AMB_W + SLOPE_W;

  typedef struct packed {
    logic [PHASE_W-1:0] phase;
    logic [COEFF_W-1:0] third;
    logic [COEFF_W-1:0] fourth;
    segment_t seg;
    logic valid;
  } corr_state_t;

  corr_state_t q;
  corr_state_t d;

  // Knees are compared lowest first; equal knees collapse a segment
  function automatic segment_t pick_segment(input logic [AMB_W-1:0] amb,
                                            input logic [KNEE_W-1:0] k1,
                                            input logic [KNEE_W-1:0] k2,
                                            input logic [KNEE_W-1:0] k3);
    segment_t s;
    if (amb < k1) s = SEG_FLAT;
    else if (amb < k2) s = SEG_ONE;
    else if (amb < k3) s = SEG_TWO;
    else s = SEG_THREE;
    return s;
  endfunction

  always_comb begin
    segment_t seg;
    logic [KNEE_W-1:0] knee;
    logic [SLOPE_W-1:0] slope;
    logic [PROD_W-1:0] prod;
    logic [PHASE_W-1:0] corr;
    seg = pick_segment(ambient, cfg.ambient_knee_first, cfg.ambient_knee_second,
                       cfg.ambient_knee_third);
    knee = '0;
    slope = '0;
    case (seg)
      SEG_ONE: begin
        knee = cfg.ambient_knee_first;
        slope = cfg.ambient_slope_one;
      end
      SEG_TWO: begin
        knee = cfg.ambient_knee_second;
        slope = cfg.ambient_slope_two;
      end
      SEG_THREE: begin
        knee = cfg.ambient_knee_third;
        slope = cfg.ambient_slope_three;
      end
      default: begin
        knee = ambient;
        slope = '0;
      end
    endcase
    // Distance past the knee times slope, scaled down
    prod = PROD_W'(ambient - knee) * PROD_W'(slope);
    corr = PHASE_W'(prod >> cfg.ambient_slope_scale);
    d = q;
    d.valid = 1'b0;
    if (measure_start) begin
      d.valid = 1'b1;
      d.seg = seg;
      d.phase = cfg.dealiased_output_select ? dealiased_phase : PHASE_W'(phase_in + corr);
      d.third = (channel == CHAN_0 && high_current) ? cfg.third_order_high_ch0 : '0;
      // Upper byte of the low-current coefficient lives outside this bank
      if (channel == CHAN_2) begin
        d.fourth = high_current ? cfg.fourth_order_high_ch2
                                : {{(COEFF_W-BYTE_W){1'b0}}, cfg.fourth_order_low_ch2};
      end else begin
        d.fourth = '0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  assign phase_out = q.phase;
  assign third_coeff = q.third;
  assign fourth_coeff = q.fourth;
  assign segment = q.seg;
  assign result_valid = q.valid;

endmodule

// ===== core/coeff_regs_top.sv
// Coefficient register bank behind the two-wire control port, feeding the
// ambient phase correction unit. Assumes an external pull-up on the data line.
//
// Functional notes
// - Register b1 bits 23:16 hold low byte of fourth-order low-current channel 2 coefficient.
// - Register b1 bits 15:0 hold third-order high-current channel 0 coefficient.
// - Register b2 bits 15:0 hold fourth-order high-current channel 2 coefficient.
// - Register b4 holds three 8-bit ambient slopes, each resetting to zero.
// - Register b5 bits 2:0 hold the 3-bit slope scale, reset zero.
// - Select bit set routes de-aliased phase to the phase output.
// - First ambient knee is bits 9:0, reset 1FFh.
// - Second ambient knee is bits 19:10, reset 1FFh.
// - Knee register resets to 7FDFFh, third-knee register (b9) to 1FFh; all others reset to zero.
// - A third 10-bit ambient knee, reset 1FFh, completes the knee set.
`timescale 1ns/1ps
module coeff_regs_top #(
  parameter logic [6:0] DEV_ADDR = corr_regs_pkg::DEFAULT_DEV_ADDR,
  parameter int PHASE_W = 16
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic ce,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic measure_start,
  input wire logic [1:0] channel,
  input wire logic high_current,
  input wire logic [corr_regs_pkg::AMB_W-1:0] ambient,
  input wire logic [PHASE_W-1:0] phase_in,
  input wire logic [PHASE_W-1:0] dealiased_phase,
  output logic [PHASE_W-1:0] phase_out,
  output logic [corr_regs_pkg::COEFF_W-1:0] third_coeff,
  output logic [corr_regs_pkg::COEFF_W-1:0] fourth_coeff,
  output logic [1:0] segment,
  output logic result_valid
);
  import corr_regs_pkg::*;

  // Address is arbitrary; zero is the general-call address and is refused
  if (DEV_ADDR == 7'h00) begin : g_addr_check
    $error("DEV_ADDR must not be zero");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] scl_sync;
    logic scl_prev;
    logic [1:0] sda_sync;
    logic sda_prev;
    port_state_t st;
    logic [3:0] bit_cnt;
    logic [BYTE_W-1:0] shift;
    logic rw;
    logic [7:0] reg_addr;
    logic [1:0] byte_idx;
    logic [COEFF_W-1:0] wbuf;
    logic [DATA_W-1:0] rbuf;
    logic drive_low;
    logic [BYTE_W-1:0] fourth_low_ch2;
    logic [COEFF_W-1:0] third_high_ch0;
    logic [COEFF_W-1:0] fourth_high_ch2;
    logic [SLOPE_W-1:0] slope_one;
    logic [SLOPE_W-1:0] slope_two;
    logic [SLOPE_W-1:0] slope_three;
    logic [SCALE_W-1:0] slope_scale;
    logic dealias_sel;
    logic [KNEE_W-1:0] knee_first;
    logic [KNEE_W-1:0] knee_second;
    logic [KNEE_W-1:0] knee_third;
  } bank_state_t;

  bank_state_t q;
  bank_state_t d;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic sda_now;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic bank_state_t reset_value();
    bank_state_t r;
    r = '0;
    r.st = ST_IDLE;
    // Idle-high line history so release of reset cannot fake a start
    r.scl_sync = '1;
    r.scl_prev = 1'b1;
    r.sda_sync = '1;
    r.sda_prev = 1'b1;
    r.knee_first = KNEES_REG_RESET[KNEE1_LSB +: KNEE_W];
    r.knee_second = KNEES_REG_RESET[KNEE2_LSB +: KNEE_W];
    r.dealias_sel = KNEES_REG_RESET[DEALIAS_BIT];
    r.knee_third = KNEE_RESET;
    return r;
  endfunction

  // Unmapped offsets and reserved bits read as zero
  function automatic logic [DATA_W-1:0] read_word(input bank_state_t r, input logic [7:0] a);
    logic [DATA_W-1:0] w;
    w = '0;
    case (a)
      REG_MIX_A: begin
        w[FOURTH_LOW_LSB +: BYTE_W] = r.fourth_low_ch2;
        w[COEFF_LSB +: COEFF_W] = r.third_high_ch0;
      end
      REG_FOURTH_HIGH_CH2: w[COEFF_LSB +: COEFF_W] = r.fourth_high_ch2;
      REG_SLOPES: begin
        w[SLOPE1_LSB +: SLOPE_W] = r.slope_one;
        w[SLOPE2_LSB +: SLOPE_W] = r.slope_two;
        w[SLOPE3_LSB +: SLOPE_W] = r.slope_three;
      end
      REG_SCALE: w[SCALE_LSB +: SCALE_W] = r.slope_scale;
      REG_KNEES: begin
        w[DEALIAS_BIT] = r.dealias_sel;
        w[KNEE1_LSB +: KNEE_W] = r.knee_first;
        w[KNEE2_LSB +: KNEE_W] = r.knee_second;
      end
      REG_KNEE_THIRD: w[KNEE3_LSB +: KNEE_W] = r.knee_third;
      default: w = '0;
    endcase
    return w;
  endfunction

  // Reserved bits are not stored, so a stray non-zero write cannot stick
  function automatic bank_state_t write_word(input bank_state_t r, input logic [7:0] a,
                                             input logic [DATA_W-1:0] w);
    bank_state_t n;
    n = r;
    case (a)
      REG_MIX_A: begin
        n.fourth_low_ch2 = w[FOURTH_LOW_LSB +: BYTE_W];
        n.third_high_ch0 = w[COEFF_LSB +: COEFF_W];
      end
      REG_FOURTH_HIGH_CH2: n.fourth_high_ch2 = w[COEFF_LSB +: COEFF_W];
      REG_SLOPES: begin
        n.slope_one = w[SLOPE1_LSB +: SLOPE_W];
        n.slope_two = w[SLOPE2_LSB +: SLOPE_W];
        n.slope_three = w[SLOPE3_LSB +: SLOPE_W];
      end
      REG_SCALE: n.slope_scale = w[SCALE_LSB +: SCALE_W];
      REG_KNEES: begin
        n.dealias_sel = w[DEALIAS_BIT];
        n.knee_first = w[KNEE1_LSB +: KNEE_W];
        n.knee_second = w[KNEE2_LSB +: KNEE_W];
      end
      REG_KNEE_THIRD: n.knee_third = w[KNEE3_LSB +: KNEE_W];
      default: n = r;
    endcase
    return n;
  endfunction

  // ----------------------------------------------------------------
  // Line events (second sync stage and its delayed copy only)
  // ----------------------------------------------------------------
  assign sda_now = q.sda_sync[1];
  assign scl_rise = q.scl_sync[1] & ~q.scl_prev;
  assign scl_fall = ~q.scl_sync[1] & q.scl_prev;
  assign start_seen = q.scl_sync[1] & q.scl_prev & q.sda_prev & ~sda_now;
  assign stop_seen = q.scl_sync[1] & q.scl_prev & ~q.sda_prev & sda_now;

  // ----------------------------------------------------------------
  // Two-wire slave
  // ----------------------------------------------------------------
  always_comb begin
    logic [DATA_W-1:0] rd_here;
    logic [DATA_W-1:0] rd_next;
    rd_here = read_word(q, q.reg_addr);
    rd_next = read_word(q, 8'(q.reg_addr + 8'h01));
    d = q;
    d.scl_sync = {q.scl_sync[0], scl_in};
    d.scl_prev = q.scl_sync[1];
    d.sda_sync = {q.sda_sync[0], sda_in};
    d.sda_prev = q.sda_sync[1];
    case (q.st)
      ST_ADDR, ST_REG, ST_WR: begin
        if (scl_rise) begin
          d.shift = {q.shift[BYTE_W-2:0], sda_now};
          d.bit_cnt = 4'(q.bit_cnt + 4'h1);
        end else if (scl_fall && q.bit_cnt == BITS_PER_BYTE) begin
          d.bit_cnt = '0;
          d.drive_low = 1'b1;
          if (q.st == ST_ADDR) begin
            if (q.shift[BYTE_W-1:1] == DEV_ADDR) begin
              d.rw = q.shift[0];
              d.st = ST_ADDR_ACK;
            end else begin
              // Not our address: stay off the line until the next start
              d.drive_low = 1'b0;
              d.st = ST_IDLE;
            end
          end else if (q.st == ST_REG) begin
            d.reg_addr = q.shift;
            d.byte_idx = '0;
            d.st = ST_REG_ACK;
          end else begin
            d.st = ST_WR_ACK;
            d.wbuf = {q.wbuf[BYTE_W-1:0], q.shift};
            if (q.byte_idx == LAST_BYTE) begin
              // Whole word lands at once; partial words never reach the bank
              d = write_word(d, q.reg_addr, {q.wbuf, q.shift});
              d.reg_addr = 8'(q.reg_addr + 8'h01);
              d.byte_idx = '0;
            end else begin
              d.byte_idx = 2'(q.byte_idx + 2'h1);
            end
          end
        end
      end
      ST_ADDR_ACK: begin
        if (scl_fall) begin
          d.drive_low = 1'b0;
          d.byte_idx = '0;
          if (q.rw) begin
            d.drive_low = ~rd_here[DATA_W-1];
            d.rbuf = {rd_here[DATA_W-2:0], 1'b0};
            d.bit_cnt = FIRST_BIT_SENT;
            d.st = ST_RD;
          end else begin
            d.st = ST_REG;
          end
        end
      end
      ST_REG_ACK, ST_WR_ACK: begin
        if (scl_fall) begin
          d.drive_low = 1'b0;
          d.st = ST_WR;
        end
      end
      ST_RD: begin
        if (scl_fall) begin
          if (q.bit_cnt == BITS_PER_BYTE) begin
            d.drive_low = 1'b0;
            d.bit_cnt = '0;
            d.st = ST_RD_ACK;
          end else begin
            d.drive_low = ~q.rbuf[DATA_W-1];
            d.rbuf = {q.rbuf[DATA_W-2:0], 1'b0};
            d.bit_cnt = 4'(q.bit_cnt + 4'h1);
          end
        end
      end
      ST_RD_ACK: begin
        if (scl_rise && sda_now) begin
          d.st = ST_IDLE;
        end else if (scl_fall) begin
          d.st = ST_RD;
          d.bit_cnt = FIRST_BIT_SENT;
          if (q.byte_idx == LAST_BYTE) begin
            // Word done: move on to the next offset
            d.reg_addr = 8'(q.reg_addr + 8'h01);
            d.byte_idx = '0;
            d.drive_low = ~rd_next[DATA_W-1];
            d.rbuf = {rd_next[DATA_W-2:0], 1'b0};
          end else begin
            d.byte_idx = 2'(q.byte_idx + 2'h1);
            d.drive_low = ~q.rbuf[DATA_W-1];
            d.rbuf = {q.rbuf[DATA_W-2:0], 1'b0};
          end
        end
      end
      default: begin
        d.drive_low = 1'b0;
      end
    endcase
    // Start and stop win over any byte in flight
    if (start_seen) begin
      d.st = ST_ADDR;
      d.bit_cnt = '0;
      d.drive_low = 1'b0;
    end else if (stop_seen) begin
      d.st = ST_IDLE;
      d.drive_low = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      q <= reset_value();
    end else if (ce) begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Open drain: the line is only ever pulled low
  assign sda_out = 1'b0;
  assign sda_oe = q.drive_low;

  corr_cfg_if cfg_bus ();

  assign cfg_bus.third_order_high_ch0 = q.third_high_ch0;
  assign cfg_bus.fourth_order_high_ch2 = q.fourth_high_ch2;
  assign cfg_bus.fourth_order_low_ch2 = q.fourth_low_ch2;
  assign cfg_bus.ambient_slope_one = q.slope_one;
  assign cfg_bus.ambient_slope_two = q.slope_two;
  assign cfg_bus.ambient_slope_three = q.slope_three;
  assign cfg_bus.ambient_slope_scale = q.slope_scale;
  assign cfg_bus.ambient_knee_first = q.knee_first;
  assign cfg_bus.ambient_knee_second = q.knee_second;
  assign cfg_bus.ambient_knee_third = q.knee_third;
  assign cfg_bus.dealiased_output_select = q.dealias_sel;

  ambient_corr_unit #(
    .PHASE_W(PHASE_W)
  ) u_corr (
    .clock(clock),
    .srst(srst),
    .ce(ce),
    .cfg(cfg_bus.corr),
    .measure_start(measure_start),
    .channel(channel),
    .high_current(high_current),
    .ambient(ambient),
    .phase_in(phase_in),
    .dealiased_phase(dealiased_phase),
    .phase_out(phase_out),
    .third_coeff(third_coeff),
    .fourth_coeff(fourth_coeff),
    .segment(segment),
    .result_valid(result_valid)
  );

endmodule

// ===== tb/coeff_regs_sva.sv
// Port-level checks of the coefficient bank and its correction outputs.
// Assumes it is bound to coeff_regs_top and sees only its ports.
`timescale 1ns/1ps
module coeff_regs_sva #(
  parameter int PHASE_W = 16
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic ce,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic measure_start,
  input wire logic [1:0] channel,
  input wire logic high_current,
  input wire logic [corr_regs_pkg::AMB_W-1:0] ambient,
  input wire logic [PHASE_W-1:0] phase_out,
  input wire logic [corr_regs_pkg::COEFF_W-1:0] third_coeff,
  input wire logic [corr_regs_pkg::COEFF_W-1:0] fourth_coeff,
  input wire logic [1:0] segment,
  input wire logic result_valid
);
  import corr_regs_pkg::*;
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  sequence take_s;
    ce && measure_start;
  endsequence
  valid_pulse_a: assert property (take_s |=> result_valid) else $error("result_valid missing");
  valid_only_a: assert property (ce && !measure_start |=> !result_valid) else $error("stray valid");
  outputs_hold_a: assert property (ce && !measure_start |=> $stable(phase_out) && $stable(segment)
    && $stable(third_coeff) && $stable(fourth_coeff)) else $error("outputs moved");
  // Reset check runs during reset itself, so it overrides the default disable
  reset_clear_a: assert property (disable iff (1'b0) srst && ce |=> !result_valid && !sda_oe
    && phase_out == '0 && segment == 2'h0 && third_coeff == '0 && fourth_coeff == '0)
    else $error("outputs not cleared");
  sda_tie_a: assert property (disable iff (1'b0) sda_out == 1'b0) else $error("data line driven high");
  seg_top_a: assert property (take_s and ambient == '1 |=> segment == 2'h3) else $error("bad segment");
  third_sel_a: assert property (take_s and !(channel == CHAN_0 && high_current) |=> third_coeff == '0)
    else $error("third coefficient leak");
  fourth_sel_a: assert property (take_s and channel != CHAN_2 |=> fourth_coeff == '0)
    else $error("fourth coefficient leak");
  fourth_low_a: assert property (take_s and channel == CHAN_2 && !high_current |=> fourth_coeff[15:8] == 8'h00)
    else $error("low current upper byte");
  cover property (take_s ##1 result_valid);
  cover property ($rose(sda_oe));
  cover property (result_valid && segment == 2'h3);
endmodule

bind coeff_regs_top coeff_regs_sva #(.PHASE_W(PHASE_W)) i_sva (.clock(clock), .srst(srst), .ce(ce),
  .sda_out(sda_out), .sda_oe(sda_oe), .measure_start(measure_start), .channel(channel),
  .high_current(high_current), .ambient(ambient), .phase_out(phase_out), .third_coeff(third_coeff),
  .fourth_coeff(fourth_coeff), .segment(segment), .result_valid(result_valid));

// ===== tb/host_model.sv
// Host controller on the two-wire port: register writes and reads.
// Assumes a pull-up on the data line; released means driving 1.
`timescale 1ns/1ps
module host_model (
  input wire logic clock,
  input wire logic sda,
  output logic scl,
  output logic sda_drv
);
  // ----------------------------------------
  // Line phases, 8 cycles each
  // ----------------------------------------
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic half();
    repeat (8) @(negedge clock);
  endtask
  // Data moves 2 cycles after the clock falls, so no false start is seen
  task automatic bit_io(input logic b, output logic r);
    repeat (2) @(negedge clock);
    sda_drv = b;
    half();
    scl = 1'b1;
    repeat (4) @(negedge clock);
    r = sda;
    repeat (4) @(negedge clock);
    scl = 1'b0;
  endtask
  task automatic start();
    repeat (2) @(negedge clock);
    sda_drv = 1'b1;
    half();
    scl = 1'b1;
    half();
    sda_drv = 1'b0;
    half();
    scl = 1'b0;
  endtask
  task automatic stop();
    repeat (2) @(negedge clock);
    sda_drv = 1'b0;
    half();
    scl = 1'b1;
    half();
    sda_drv = 1'b1;
    half();
  endtask
  task automatic byte_w(input logic [7:0] v, inout logic ok);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(v[i], r);
    end
    bit_io(1'b1, r);
    ok = ok & !r;
  endtask
  // ----------------------------------------
  // Register access
  // ----------------------------------------
  task automatic write_reg(input logic [6:0] a, input logic [7:0] off, input logic [23:0] d, output logic ok);
    ok = 1'b1;
    start();
    byte_w({a, 1'b0}, ok);
    byte_w(off, ok);
    for (int i = 2; i >= 0; i--) begin
      byte_w(d[8*i +: 8], ok);
    end
    stop();
  endtask
  task automatic read_reg(input logic [6:0] a, input logic [7:0] off, output logic [23:0] d);
    logic ok;
    logic r;
    ok = 1'b1;
    start();
    byte_w({a, 1'b0}, ok);
    byte_w(off, ok);
    start();
    byte_w({a, 1'b1}, ok);
    for (int i = 0; i < 24; i++) begin
      bit_io(1'b1, r);
      d = {d[22:0], r};
      if (i % 8 == 7) begin
        bit_io(i == 23, r);
      end
    end
    stop();
  endtask
endmodule

// ===== tb/tb_coeff_regs_top.sv
// Self-checking bench: register access over the two-wire port, interleaved with measurements.
// Assumes host_model drives the port lines and a pull-up holds the data line.
`timescale 1ns/1ps
module tb_coeff_regs_top;
  import corr_regs_pkg::*;
  // ----------------------------------------
  // Harness
  // ----------------------------------------
  localparam logic [6:0] DEV = DEFAULT_DEV_ADDR;
  logic clock, srst, ce, scl, host_sda, sda, sda_out, sda_oe;
  logic measure_start, high_current, result_valid;
  logic [1:0] channel, segment;
  logic [AMB_W-1:0] ambient;
  logic [15:0] phase_in, dealiased_phase, phase_out, third_coeff, fourth_coeff;
  int err_total, n_tests;
  assign sda = host_sda & (sda_oe ? sda_out : 1'b1);
  coeff_regs_top i_dut (.clock(clock), .srst(srst), .ce(ce), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .measure_start(measure_start), .channel(channel), .high_current(high_current),
    .ambient(ambient), .phase_in(phase_in), .dealiased_phase(dealiased_phase), .phase_out(phase_out),
    .third_coeff(third_coeff), .fourth_coeff(fourth_coeff), .segment(segment), .result_valid(result_valid));
  host_model i_host (.clock(clock), .sda(sda), .scl(scl), .sda_drv(host_sda));
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] off, input logic [23:0] d, input logic ok);
    logic ack;
    i_host.write_reg(a, off, d, ack);
    chk("ack", {23'h0, ok}, {23'h0, ack});
  endtask
  task automatic rd(input logic [7:0] off, input logic [23:0] e);
    logic [23:0] d;
    i_host.read_reg(DEV, off, d);
    chk($sformatf("reg %h", off), e, d);
  endtask
  task automatic meas(input logic [1:0] ch, input logic hi, input logic [9:0] amb, input logic [15:0] ph, dph);
    @(negedge clock);
    measure_start = 1'b1;
    channel = ch;
    high_current = hi;
    ambient = amb;
    phase_in = ph;
    dealiased_phase = dph;
    @(negedge clock);
    measure_start = 1'b0;
    chk("valid", 24'h1, {23'h0, result_valid});
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    logic [7:0] offs [6] = '{REG_MIX_A, REG_FOURTH_HIGH_CH2, REG_SLOPES, REG_SCALE, REG_KNEES, REG_KNEE_THIRD};
    logic [23:0] vals [6] = '{24'h0, 24'h0, 24'h0, 24'h0, 24'h07_fdff, 24'h1ff};
    for (int i = 0; i < 6; i++) begin
      rd(offs[i], vals[i]);
    end
  endtask
  task automatic t_coeffs();
    wr(DEV, REG_MIX_A, 24'ha5_1234, 1'b1);
    rd(REG_MIX_A, 24'ha5_1234);
    meas(CHAN_0, 1'b1, 10'h0, 16'h0, 16'h0);
    chk("third", 24'h1234, {8'h0, third_coeff});
    chk("fourth", 24'h0, {8'h0, fourth_coeff});
    meas(CHAN_2, 1'b0, 10'h0, 16'h0, 16'h0);
    chk("fourth", 24'ha5, {8'h0, fourth_coeff});
    chk("third", 24'h0, {8'h0, third_coeff});
    wr(DEV, REG_FOURTH_HIGH_CH2, 24'h00_beef, 1'b1);
    rd(REG_FOURTH_HIGH_CH2, 24'hbeef);
    meas(CHAN_2, 1'b1, 10'h0, 16'h0, 16'h0);
    chk("fourth", 24'hbeef, {8'h0, fourth_coeff});
    meas(2'h1, 1'b1, 10'h0, 16'h0, 16'h0);
    chk("fourth", 24'h0, {8'h0, fourth_coeff});
  endtask
  task automatic t_pwl();
    logic [9:0] amb [4] = '{10'h050, 10'h180, 10'h250, 10'h3ff};
    logic [9:0] kn [4] = '{10'h0, 10'h100, 10'h200, 10'h300};
    logic [7:0] sl [4] = '{8'h0, 8'h2, 8'h4, 8'h6};
    logic [15:0] e;
    wr(DEV, REG_SLOPES, 24'h06_0402, 1'b1);
    rd(REG_SLOPES, 24'h06_0402);
    wr(DEV, REG_SCALE, 24'h00_0001, 1'b1);
    rd(REG_SCALE, 24'h1);
    wr(DEV, REG_KNEES, 24'h1f_ffff, 1'b1);
    rd(REG_KNEES, 24'h1f_ffff);
    meas(CHAN_0, 1'b1, 10'h3ff, 16'h1111, 16'h2222);
    chk("phase", 24'h2222, {8'h0, phase_out});
    wr(DEV, REG_KNEES, 24'h08_0100, 1'b1);
    rd(REG_KNEES, 24'h08_0100);
    wr(DEV, REG_KNEE_THIRD, 24'h300, 1'b1);
    rd(REG_KNEE_THIRD, 24'h300);
    for (int i = 0; i < 4; i++) begin
      e = 16'h1000 + ((16'(amb[i] - kn[i]) * 16'(sl[i])) >> 1);
      meas(CHAN_0, 1'b1, amb[i], 16'h1000, 16'h0);
      chk("segment", 24'(i), {22'h0, segment});
      chk("phase", {8'h0, e}, {8'h0, phase_out});
    end
  endtask
  task automatic t_refuse();
    wr(DEV, 8'hb3, 24'h12_3456, 1'b1);
    rd(8'hb3, 24'h0);
    wr(DEV ^ 7'h01, REG_MIX_A, 24'h0, 1'b0);
    rd(REG_MIX_A, 24'ha5_1234);
  endtask
  // ----------------------------------------
  // Run control
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    srst = 1'b1;
    ce = 1'b1;
    measure_start = 1'b0;
    channel = 2'h0;
    high_current = 1'b0;
    ambient = '0;
    phase_in = 16'h0;
    dealiased_phase = 16'h0;
    repeat (16) @(negedge clock);
    srst = 1'b0;
    repeat (4) @(negedge clock);
    t_reset();
    t_coeffs();
    t_pwl();
    t_refuse();
    finish_test();
  end
  initial begin
    repeat (90000) @(posedge clock);
    err_total++;
    finish_test();
  end
endmodule
